// [hdl/rmi_core.sv]
`timescale 1ns/1ps
module rmi_core (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Data memory port, read data one cycle after mem_re
   output logic [11:0] mem_addr,
   output logic mem_re,
   output logic mem_we,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata
);
   import rmi_pkg::*;

   rmi_dec_if dif ();
   rmi_decode u_dec (.d(dif));

   rmi_phase_t phase_reg, phase_next;
   logic cyc2_reg, cyc2_next;
   logic [15:0] instr_reg, instr_next;
   logic [15:0] instr2_reg, instr2_next;
   logic ext_reg, ext_next;
   logic [3:0] bank_reg, bank_next;
   logic [11:0] fsr2_reg, fsr2_next;
   logic [7:0] w_reg, w_next;
   logic n_reg, n_next;
   logic z_reg, z_next;
   logic bad_reg, bad_next;
   logic [7:0] data_reg, data_next;
   logic [11:0] mem_addr_reg, mem_addr_next;
   logic mem_re_reg, mem_re_next;
   logic mem_we_reg, mem_we_next;
   logic [7:0] mem_wdata_reg, mem_wdata_next;
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic [7:0] src_val;
   logic busy;
   logic setup;
   logic wr_take;
   logic mapped;

   assign dif.instr = instr_reg;
   assign dif.instr2 = instr2_reg;
   assign dif.ext_en = ext_reg;
   assign dif.bank = bank_reg;
   assign dif.fsr2 = fsr2_reg;

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign mem_addr = mem_addr_reg;
   assign mem_re = mem_re_reg;
   assign mem_we = mem_we_reg;
   assign mem_wdata = mem_wdata_reg;

   // Bus qualifiers; writes land only at the accepting edge
   // Source byte as it stands in Q3; data_reg only catches it at the end of Q3
   assign src_val = dif.src_is_w ? w_reg : mem_rdata;
   assign busy = (phase_reg != RMI_IDLE);
   assign setup = psel && !penable;
   assign wr_take = psel && penable && pready_reg && pwrite;
   assign mapped = (paddr == ADDR_INSTR) || (paddr == ADDR_INSTR2) || (paddr == ADDR_CTRL) ||
                   (paddr == ADDR_BANK) || (paddr == ADDR_WREG) ||
                   (paddr == ADDR_STATUS) || (paddr == ADDR_FSR2);

   // APB answer: prepared in setup, shown in the access cycle, no wait states
   always_comb begin
      pready_next = setup;
      pslverr_next = 1'b0;
      prdata_next = 32'h0000_0000;
      if (setup) begin
         // Config writes while executing would tear an instruction, so refuse them
         pslverr_next = !mapped || (pwrite && busy && paddr != ADDR_STATUS);
         if (!pwrite) begin
            case (paddr)
               ADDR_INSTR: prdata_next = {16'h0000, instr_reg};
               ADDR_INSTR2: prdata_next = {16'h0000, instr2_reg};
               ADDR_CTRL: prdata_next = {31'h0, ext_reg};
               ADDR_BANK: prdata_next = {28'h000_0000, bank_reg};
               ADDR_WREG: prdata_next = {24'h00_0000, w_reg};
               ADDR_STATUS: prdata_next = {28'h000_0000, bad_reg, n_reg, z_reg, busy};
               ADDR_FSR2: prdata_next = {20'h0_0000, fsr2_reg};
               default: prdata_next = 32'h0000_0000;
            endcase
         end
      end
   end

   // Instruction sequencer and architectural state
   always_comb begin
      phase_next = phase_reg;
      cyc2_next = cyc2_reg;
      instr_next = instr_reg;
      instr2_next = instr2_reg;
      ext_next = ext_reg;
      bank_next = bank_reg;
      fsr2_next = fsr2_reg;
      w_next = w_reg;
      n_next = n_reg;
      z_next = z_reg;
      bad_next = bad_reg;
      data_next = data_reg;
      mem_addr_next = mem_addr_reg;
      mem_re_next = 1'b0;
      mem_we_next = 1'b0;
      mem_wdata_next = mem_wdata_reg;
      case (phase_reg)
         RMI_IDLE: begin
            // Software issues an instruction by writing INSTR
            if (wr_take) begin
               case (paddr)
                  ADDR_INSTR: begin
                     instr_next = pwdata[15:0];
                     phase_next = RMI_Q1;
                     cyc2_next = 1'b0;
                     bad_next = 1'b0;
                  end
                  ADDR_INSTR2: instr2_next = pwdata[15:0];
                  ADDR_CTRL: ext_next = pwdata[CTRL_EXT];
                  ADDR_BANK: bank_next = pwdata[3:0];
                  ADDR_WREG: w_next = pwdata[7:0];
                  ADDR_FSR2: fsr2_next = pwdata[11:0];
                  default: ;
               endcase
            end
         end
         RMI_Q1: begin
            // Decode; source read goes out in Q2 of the first cycle
            phase_next = RMI_Q2;
            if (!cyc2_reg && (dif.is_move_file || dif.is_move_rr) && !dif.src_is_w) begin
               mem_re_next = 1'b1;
               mem_addr_next = dif.src_loc;
            end
         end
         RMI_Q2: begin
            // Second cycle of the two-word move does no dummy read
            phase_next = RMI_Q3;
         end
         RMI_Q3: begin
            phase_next = RMI_Q4;
            if (!cyc2_reg) begin
               data_next = src_val;
            end
            // Memory write is staged so it lands in Q4; write-back takes the fresh byte
            if (dif.is_move_file && dif.dir_file && !dif.dst_is_w) begin
               mem_we_next = 1'b1;
               mem_addr_next = dif.dst_loc;
               mem_wdata_next = src_val;
            end else if (dif.is_move_rr && cyc2_reg && !dif.dst_is_w && !dif.bad_dst) begin
               mem_we_next = 1'b1;
               mem_addr_next = dif.dst_loc;
               mem_wdata_next = data_reg;
            end
         end
         RMI_Q4: begin
            phase_next = RMI_IDLE;
            if (dif.is_move_file) begin
               n_next = data_reg[7];
               z_next = (data_reg == RST_BYTE);
               if (!dif.dir_file || dif.dst_is_w) begin
                  w_next = data_reg;
               end
            end else if (dif.is_move_rr && !cyc2_reg) begin
               phase_next = RMI_Q1;
               cyc2_next = 1'b1;
            end else if (dif.is_move_rr) begin
               bad_next = dif.bad_dst;
               if (dif.dst_is_w) begin
                  w_next = data_reg;
               end
            end
         end
         default: phase_next = RMI_IDLE;
      endcase
   end

   // Registers only; synchronous reset
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         phase_reg <= RMI_IDLE;
         cyc2_reg <= 1'b0;
         instr_reg <= RST_WORD;
         instr2_reg <= RST_WORD;
         ext_reg <= 1'b0;
         bank_reg <= RST_BANK;
         fsr2_reg <= RST_ADDR;
         w_reg <= RST_BYTE;
         n_reg <= 1'b0;
         z_reg <= 1'b0;
         bad_reg <= 1'b0;
         data_reg <= RST_BYTE;
         mem_addr_reg <= RST_ADDR;
         mem_re_reg <= 1'b0;
         mem_we_reg <= 1'b0;
         mem_wdata_reg <= RST_BYTE;
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         cyc2_reg <= cyc2_next;
         instr_reg <= instr_next;
         instr2_reg <= instr2_next;
         ext_reg <= ext_next;
         bank_reg <= bank_next;
         fsr2_reg <= fsr2_next;
         w_reg <= w_next;
         n_reg <= n_next;
         z_reg <= z_next;
         bad_reg <= bad_next;
         data_reg <= data_next;
         mem_addr_reg <= mem_addr_next;
         mem_re_reg <= mem_re_next;
         mem_we_reg <= mem_we_next;
         mem_wdata_reg <= mem_wdata_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   // Checks on the sequencer and memory port
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   sequence seq_one_cycle;
      (phase_reg == RMI_Q2) ##1 (phase_reg == RMI_Q3) ##1 (phase_reg == RMI_Q4);
   endsequence

   sequence seq_move_rr_run;
      seq_one_cycle ##1 (phase_reg == RMI_Q1 && cyc2_reg) ##1 seq_one_cycle
         ##1 (phase_reg == RMI_IDLE);
   endsequence

   chk_file_move_len: assert property (
      (phase_reg == RMI_Q1 && dif.is_move_file) |=> seq_one_cycle ##1 (phase_reg == RMI_IDLE))
      else $error("single-word move not one instruction cycle");

   chk_rr_move_len: assert property (
      (phase_reg == RMI_Q1 && !cyc2_reg && dif.is_move_rr) |=> seq_move_rr_run)
      else $error("two-word move not two instruction cycles");

   chk_src_read_q2: assert property (
      mem_re_reg |-> (phase_reg == RMI_Q2 && !cyc2_reg && $past(phase_reg) == RMI_Q1))
      else $error("source read outside first-cycle Q2");

   chk_write_q4: assert property (
      mem_we_reg |-> (phase_reg == RMI_Q4) && (dif.is_move_file || cyc2_reg))
      else $error("memory write outside proper Q4");

   chk_rr_flags_kept: assert property (
      (phase_reg == RMI_Q1 && !cyc2_reg && dif.is_move_rr) |-> ##1 $stable({n_reg, z_reg})[*8])
      else $error("two-word move changed a flag");

   chk_file_flags: assert property (
      (phase_reg == RMI_Q4 && dif.is_move_file) |=>
         (z_reg == (data_reg == 8'h00)) && (n_reg == data_reg[7]))
      else $error("single-word move flags wrong");

   chk_bank_addr: assert property (
      (mem_re_reg && dif.is_move_file && instr_reg[8]) |-> mem_addr_reg == {bank_reg, instr_reg[7:0]})
      else $error("banked address not from bank select");

   chk_indexed_addr: assert property (
      (mem_re_reg && dif.is_move_file && !instr_reg[8] && ext_reg && instr_reg[7:0] <= 8'h5F)
         |-> mem_addr_reg == 12'(fsr2_reg + {4'h0, instr_reg[7:0]}))
      else $error("indexed literal offset address wrong");

   chk_rr_src_addr: assert property (
      (mem_re_reg && dif.is_move_rr) |-> mem_addr_reg == instr_reg[11:0])
      else $error("two-word move source address wrong");

   chk_protected_dst: assert property (
      mem_we_reg |-> !rmi_is_protected(mem_addr_reg) || dif.is_move_file)
      else $error("write to protected location by two-word move");

   chk_w_dest: assert property (
      (phase_reg == RMI_Q4 && cyc2_reg && dif.is_move_rr && dif.dst_is_w) |=> w_reg == $past(data_reg))
      else $error("working register not written as destination");
endmodule

// [hdl/rmi_dec_if.sv]
`timescale 1ns/1ps
interface rmi_dec_if;
   logic [15:0] instr;
   logic [15:0] instr2;
   logic ext_en;
   logic [3:0] bank;
   logic [11:0] fsr2;
   logic is_move_file;
   logic is_move_rr;
   logic dir_file;
   logic [11:0] src_loc;
   logic [11:0] dst_loc;
   logic src_is_w;
   logic dst_is_w;
   logic bad_dst;

   modport dec (
      input instr, instr2, ext_en, bank, fsr2,
      output is_move_file, is_move_rr, dir_file, src_loc, dst_loc, src_is_w, dst_is_w,
      bad_dst
   );
   modport core (
      output instr, instr2, ext_en, bank, fsr2,
      input is_move_file, is_move_rr, dir_file, src_loc, dst_loc, src_is_w, dst_is_w,
      bad_dst
   );
endinterface

// [hdl/rmi_decode.sv]
`timescale 1ns/1ps
module rmi_decode (
   // Decoder side of the carrier
   rmi_dec_if.dec d
);
   import rmi_pkg::*;

   logic [7:0] f;
   logic acc;
   logic [11:0] banked;

   // Field split and opcode match
   always_comb begin
      f = d.instr[7:0];
      acc = d.instr[8];
      d.dir_file = d.instr[9];
      d.is_move_file = (d.instr[15:10] == OPC_MOVE_FILE);
      d.is_move_rr = (d.instr[15:12] == PFX_SRC) && (d.instr2[15:12] == PFX_DST);
   end

   // Single-word address: an 8-bit offset into one bank, or added to FSR2 when indexed
   always_comb begin
      if (acc) begin
         banked = {d.bank, f};
      end else if (f <= ACCESS_LIMIT && d.ext_en) begin
         banked = 12'(d.fsr2 + {4'h0, f});
      end else if (f <= ACCESS_LIMIT) begin
         banked = {4'h0, f};
      end else begin
         banked = {ACCESS_HI_BANK, f};
      end
   end

   // Full 12-bit locations for the two-word move
   always_comb begin
      d.src_loc = d.is_move_rr ? d.instr[11:0] : banked;
      d.dst_loc = d.is_move_rr ? d.instr2[11:0] : banked;
      d.src_is_w = rmi_is_wreg(d.src_loc);
      d.dst_is_w = rmi_is_wreg(d.dst_loc);
      d.bad_dst = d.is_move_rr && rmi_is_protected(d.dst_loc);
   end
endmodule

// [hdl/rmi_pkg.sv]
// Overview of operation
// - Single-word move copies file register to W (d=0) or back to itself; sets N, Z.
// - Single-word move register field is an offset inside one 256-byte bank.
// - Access bit 0 selects access bank; 1 uses bank select register for bank.
// - Access bit 0, extended set on, field at most 95: indexed literal offset.
// - Two-word move: prefix 1100 source, prefix 1111 destination, flags untouched.
// - Two-word move source may be any address 000h to FFFh; destination any except FF9h and FFDh to FFFh.
// - Working register may be source or destination of the two-word move.
// - Two-word move reads source in cycle 1 phase 2, writes in cycle 2 phase 4.
package rmi_pkg;

   // Register byte offsets on the APB side
   localparam logic [7:0] ADDR_INSTR = 8'h00;
   localparam logic [7:0] ADDR_INSTR2 = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_BANK = 8'h0C;
   localparam logic [7:0] ADDR_WREG = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;
   localparam logic [7:0] ADDR_FSR2 = 8'h18;

   // Field positions inside the STATUS and CTRL registers
   localparam int STAT_BUSY = 0;
   localparam int STAT_ZERO = 1;
   localparam int STAT_NEG = 2;
   localparam int STAT_BADDST = 3;
   localparam int CTRL_EXT = 0;

   // Values after reset
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [11:0] RST_ADDR = 12'h000;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [3:0] RST_BANK = 4'h0;

   // Instruction encodings
   localparam logic [5:0] OPC_MOVE_FILE = 6'h14;
   localparam logic [3:0] PFX_SRC = 4'hC;
   localparam logic [3:0] PFX_DST = 4'hF;
   localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

   // Special data-space locations
   localparam logic [11:0] LOC_WREG = 12'hFE8;
   localparam logic [11:0] LOC_PC_LOW = 12'hFF9;
   localparam logic [11:0] LOC_TOS_UPPER = 12'hFFF;
   localparam logic [11:0] LOC_TOS_HIGH = 12'hFFE;
   localparam logic [11:0] LOC_TOS_LOW = 12'hFFD;

   // Four-phase instruction cycle, Gray along Q1..Q4
   typedef enum logic [2:0] {
      RMI_IDLE = 3'h0,
      RMI_Q1 = 3'h1,
      RMI_Q2 = 3'h3,
      RMI_Q3 = 3'h2,
      RMI_Q4 = 3'h6
   } rmi_phase_t;

   // Working register is mapped into the data space
   function automatic logic rmi_is_wreg(input logic [11:0] loc);
      rmi_is_wreg = (loc == LOC_WREG);
   endfunction

   // Locations the two-word move may not write
   function automatic logic rmi_is_protected(input logic [11:0] loc);
      rmi_is_protected = (loc == LOC_PC_LOW) || (loc == LOC_TOS_UPPER) ||
                         (loc == LOC_TOS_HIGH) || (loc == LOC_TOS_LOW);
   endfunction

endpackage

// [verification/rmi_mem_model.sv]
`timescale 1ns/1ps
// Behavioural data space behind the core, one-cycle read latency
module rmi_mem_model (
   // Clock
   input wire logic sys_clk,
   // Access from the core
   input wire logic [11:0] mem_addr,
   input wire logic mem_re,
   input wire logic mem_we,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata
);
   logic [7:0] mem [0:4095];
   logic [7:0] rdata_reg;
   logic valid_reg = 1'b0;

   // Answer only in the cycle after a read; writes land at the edge
   always @(posedge sys_clk) begin
      valid_reg <= (mem_re === 1'b1);
      if (mem_re === 1'b1) begin
         rdata_reg <= mem[mem_addr];
      end
      if (mem_we === 1'b1) begin
         mem[mem_addr] <= mem_wdata;
      end
   end

   // Inverse outside the answer cycle, so a late sample cannot match
   assign mem_rdata = valid_reg ? rdata_reg : ~rdata_reg;
endmodule

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
   import rmi_pkg::*;
   logic sys_clk, rst, psel, penable, pwrite, pready, pslverr, mem_re, mem_we, e;
   logic [7:0] paddr, mem_wdata, mem_rdata, wd;
   logic [31:0] pwdata, prdata, rd;
   logic [11:0] mem_addr, wa, ra;
   int err_count, cmp_count, cyc, t0, re_at, we_at, re_cnt, we_cnt;

   rmi_core dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
   rmi_mem_model u_mem (.sys_clk(sys_clk), .mem_addr(mem_addr), .mem_re(mem_re),
      .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   // Clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Memory port monitor, cycle stamps of reads and writes
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (mem_re === 1'b1) begin
         re_cnt <= re_cnt + 1;
         re_at <= cyc;
         ra <= mem_addr;
      end
      if (mem_we === 1'b1) begin
         we_cnt <= we_cnt + 1;
         we_at <= cyc;
         wa <= mem_addr;
         wd <= mem_wdata;
      end
   end

   task results;
      $display("compares %0d errors %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      // Loop has no bound; n is then checked to be 1, and a hang is left to the watchdog
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1);
      chk(n, 1);
      rd = prdata;
      e = pslverr;
      if (w && a == ADDR_INSTR) t0 = cyc;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask

   task rdchk(input logic [7:0] a, input logic [31:0] exp, input logic eexp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, e}, {31'h0, eexp});
   endtask

   // Issue an instruction, optionally poke a config register while busy
   task go(input logic [15:0] ins, input logic [15:0] ins2, input logic probe);
      int n;
      n = 0;
      apb(1'b1, ADDR_INSTR2, {16'h0, ins2});
      re_cnt = 0;
      we_cnt = 0;
      apb(1'b1, ADDR_INSTR, {16'h0, ins});
      if (probe) begin
         apb(1'b1, ADDR_BANK, 32'h0);
         chk({31'h0, e}, 32'h1);
      end
      do begin
         apb(1'b0, ADDR_STATUS, 32'h0);
         n++;
      end while (rd[STAT_BUSY] !== 1'b0 && n < 20);
      chk({31'h0, rd[STAT_BUSY]}, 32'h0);
   endtask

   // Single-word move: value at loc, expected W afterwards
   task sv(input logic [15:0] ins, input logic [11:0] loc, input logic [7:0] v,
      input logic [7:0] wexp);
      u_mem.mem[loc] = v;
      go(ins, 16'h0000, 1'b0);
      rdchk(ADDR_WREG, {24'h0, wexp}, 1'b0);
      rdchk(ADDR_STATUS, {29'h0, v[7], v == 8'h00, 1'b0}, 1'b0);
      chk(ra, loc);
      chk(re_at - t0, 2);
      if (ins[9]) begin
         chk(we_at - t0, 4);
         chk({wa, wd}, {loc, v});
      end else begin
         chk(we_cnt, 0);
      end
   endtask

   // Two-word move: expected status afterwards in st
   task rr(input logic [11:0] s, input logic [11:0] dd, input logic [7:0] v,
      input logic [31:0] st);
      if (s != LOC_WREG) u_mem.mem[s] = v;
      else apb(1'b1, ADDR_WREG, {24'h0, v});
      go({PFX_SRC, s}, {PFX_DST, dd}, 1'b0);
      rdchk(ADDR_STATUS, st, 1'b0);
      chk(re_cnt, (s != LOC_WREG));
      if (s != LOC_WREG) chk({ra, 20'(re_at - t0)}, {s, 20'd2});
      if (st[STAT_BADDST] || dd == LOC_WREG) begin
         chk(we_cnt, 0);
      end else begin
         chk({wa, wd, 12'(we_at - t0)}, {dd, v, 12'd8});
         chk(u_mem.mem[dd], v);
      end
      if (dd == LOC_WREG) rdchk(ADDR_WREG, {24'h0, v}, 1'b0);
   endtask

   // Watchdog, far beyond the length of the sequence
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      results;
   end

   initial begin
      logic [11:0] prot [4];
      prot = '{LOC_PC_LOW, LOC_TOS_UPPER, LOC_TOS_HIGH, LOC_TOS_LOW};
      err_count = 0;
      cmp_count = 0;
      cyc = 0;
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rdchk(ADDR_STATUS, 32'h0, 1'b0);
      rdchk(ADDR_WREG, 32'h0, 1'b0);
      rdchk(8'h40, 32'h0, 1'b1);
      apb(1'b1, ADDR_WREG, 32'h33);
      apb(1'b1, ADDR_BANK, 32'h3);
      sv(16'h5180, 12'h380, 8'h00, 8'h00);
      sv(16'h5060, 12'hF60, 8'h85, 8'h85);
      sv(16'h5210, 12'h010, 8'h7F, 8'h85);
      apb(1'b1, ADDR_CTRL, 32'h1);
      apb(1'b1, ADDR_FSR2, 32'h200);
      sv(16'h505F, 12'h25F, 8'h40, 8'h40);
      sv(16'h5060, 12'hF60, 8'h85, 8'h85);
      apb(1'b1, ADDR_BANK, 32'hF);
      sv(16'h51FF, 12'hFFF, 8'h00, 8'h00);
      apb(1'b1, ADDR_CTRL, 32'h0);
      rr(12'h000, 12'hF80, 8'h5A, 32'h2);
      rr(12'hFFF, 12'h000, 8'hA5, 32'h2);
      rr(LOC_WREG, 12'h100, 8'h3C, 32'h2);
      rr(12'h200, LOC_WREG, 8'hC3, 32'h2);
      foreach (prot[i]) rr(12'h123, prot[i], 8'h11, 32'hA);
      rr(12'h123, 12'h456, 8'h77, 32'h2);
      // Second word without its prefix: nothing moves, busy refuses config
      go({PFX_SRC, 12'h123}, 16'hE456, 1'b1);
      chk(re_cnt + we_cnt, 0);
      rdchk(ADDR_BANK, 32'hF, 1'b0);
      results;
   end
endmodule
